// >>> dacdec_pkg.sv
// Package for the dual channel serial command decoder.
// Assumes one 25 MHz system clock and a synchronous active-high reset.
package dacdec_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [3:0] CFG_TYPE_CODE = 4'h9;
  // Default device type identifier; value is arbitrary
  localparam logic [3:0] DEFAULT_TYPE_ID = 4'h6;
  localparam logic [7:0] CFG_RESET = {DEFAULT_TYPE_ID, 4'h6};
  localparam int unsigned CFG_LOCK_BIT = 0;
  localparam int unsigned CFG_POR_LSB = 1;
  localparam int unsigned CFG_PD_HIZ_BIT = 3;
  localparam int unsigned CFG_TYPE_LSB = 4;
  localparam logic [3:0] GRP_SLEEP = 4'h8;
  localparam logic [3:0] GRP_LOAD_ONE = 4'h9;
  localparam logic [3:0] GRP_LOAD_TWO = 4'ha;
  localparam logic [3:0] GRP_LOAD_BOTH = 4'hb;
  localparam logic [3:0] GRP_CLEAR = 4'hd;
  localparam logic [3:0] GRP_FILL = 4'he;
  localparam logic [3:0] GRP_RESTORE = 4'hf;
  localparam logic [1:0] POR_ZERO = 2'h0;
  localparam logic [1:0] POR_ONES = 2'h1;
  localparam logic [1:0] POR_MID = 2'h2;
  localparam logic [9:0] VAL_ZERO = 10'h000;
  localparam logic [9:0] VAL_FULL = 10'h3ff;
  localparam logic [9:0] VAL_MID = 10'h200;
  localparam logic [9:0] NV_RESET = 10'h000;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
endpackage : dacdec_pkg

// >>> serial_if.sv
// Interface between the bus framer and the command decoder.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface serial_if;
  logic start_p;
  logic stop_p;
  logic byte_p;
  logic [7:0] rx_byte;
  logic [3:0] byte_idx;
  logic ack_req;
  logic tx_bit;
  logic tx_req;
  logic tx_en;
  logic rd_mode;
  modport framer (output start_p, stop_p, byte_p, rx_byte, byte_idx, rd_mode,
                  input ack_req, tx_bit, tx_en);
  modport decoder (input start_p, stop_p, byte_p, rx_byte, byte_idx, rd_mode,
                   output ack_req, tx_bit, tx_en);
endinterface : serial_if

// >>> serial_framer.sv
// Two-wire bus framer: finds start, stop, bytes, drives acknowledge.
// Assumes bus pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
module serial_framer
  import dacdec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  serial_if.framer sif
);
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [3:0] idx_ff;
  logic drive_ff;
  logic rd_ff;
  logic busy_ff;
  wire scl_rise = scl_sync_ff[1] & ~scl_d_ff;
  wire scl_fall = ~scl_sync_ff[1] & scl_d_ff;
  wire start_c = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
  wire stop_c = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];
  // Count 8 means all data bits in; count 9 is the answer slot
  wire ninth = (bit_cnt_ff == 4'h9);

  // -----------------------------------------------------------
  // Synchronisers and edge history
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  // -----------------------------------------------------------
  // Bit counter, shifter, acknowledge drive
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || start_c || stop_c) begin
      bit_cnt_ff <= BIT_CNT_RESET;
      idx_ff <= 4'h0;
      drive_ff <= 1'b0;
      rd_ff <= 1'b0;
      busy_ff <= start_c;
    end else if (busy_ff && scl_rise && (bit_cnt_ff < 4'h8)) begin
      // Bits counted on rising edges, so the fall after start is ignored
      shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (busy_ff && scl_fall) begin
      if (ninth) begin
        bit_cnt_ff <= BIT_CNT_RESET;
        idx_ff <= idx_ff + 4'h1;
        busy_ff <= sif.ack_req | rd_ff;
        if (idx_ff == 4'h0) begin
          rd_ff <= shift_ff[0];
        end
        drive_ff <= 1'b0;
      end else if (bit_cnt_ff == 4'h8) begin
        // Answer slot opens; decision arrives on this same edge
        bit_cnt_ff <= 4'h9;
        drive_ff <= 1'b1;
      end
    end
  end

  assign sif.start_p = start_c;
  assign sif.stop_p = stop_c;
  assign sif.byte_p = busy_ff && scl_fall && (bit_cnt_ff == 4'h8);
  assign sif.rx_byte = shift_ff;
  assign sif.byte_idx = idx_ff;
  assign sif.rd_mode = rd_ff;
  // Low on the ninth clock for acknowledge, or data zero bits in read
  assign sda_oe_o = (drive_ff & sif.ack_req) | (sif.tx_en & ~sif.tx_bit);
endmodule : serial_framer

// >>> dual_dac_serial_command_decoder.sv
// Command decoder for a dual 10-bit converter on the two-wire bus.
// Assumes the master owns the serial clock; pins arrive asynchronously.
// Notes on behaviour
// - Address byte: type, strap bits, direction
// - Write: address, ack, command, ack, data
// - Nibble 1001 loads channel one value
// - 1010 channel two, 1011 both channels
// - No stop: channel register only updated
// - Stop after data: also store nonvolatile
// - Clear command loads zeros to selection
// - Fill command loads ones to selection
// - Restore copies nonvolatile to selected channels
// - Sleep powers down selected channel outputs
// - Two-byte commands immediate, never store nonvolatile
// - Config register reached with type 1001
// - Lock bit blocks config read and write
// - Config bits 2:1 pick power-on value
// - Config bit 3 picks sleep output state
// - Config bits 7:4 give matched type id
// - Unit select gates bus participation
// - Unit select active high
// - Acknowledge only on matching address
`timescale 1ns/10ps
module dual_dac_serial_command_decoder
  import dacdec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] strap_addr_i,
  input wire logic unit_sel_i,
  input wire logic unit_sel_mode_i,
  output logic [9:0] chan_one_value_o,
  output logic [9:0] chan_two_value_o,
  output logic [9:0] nv_one_value_o,
  output logic [9:0] nv_two_value_o,
  output logic [1:0] sleep_o,
  output logic sleep_hiz_o,
  output logic [7:0] dac_configuration_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b011,
    ST_DATA = 3'b010,
    ST_DONE = 3'b110,
    ST_CFG = 3'b111,
    ST_CFGRD = 3'b101
  } dec_state_e;

  serial_if sif ();

  logic [1:0] sel_sync_ff;
  logic [2:0] strap_ff;
  logic strap_taken_ff;
  dec_state_e state_ff;
  dec_state_e nxt_state;
  logic [7:0] cmd_ff;
  logic [9:0] pend_ff;
  logic [1:0] pend_tgt_ff;
  logic pend_ff_valid;
  logic [9:0] chan_ff [2];
  logic [9:0] nv_ff [2];
  logic [1:0] sleep_ff;
  logic [7:0] cfg_ff;
  logic por_done_ff;
  logic [7:0] rd_shift_ff;
  logic ack_ff;

  // -----------------------------------------------------------
  // Bus framing
  // -----------------------------------------------------------
  serial_framer u_framer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .sif(sif)
  );

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  // -----------------------------------------------------------
  // Unit select sync and strap capture
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_sync_ff <= 2'h0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], unit_sel_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_ff <= 3'h0;
      strap_taken_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_ff <= strap_addr_i;
      strap_taken_ff <= 1'b1;
    end
  end

  // -----------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------
  wire selected = !unit_sel_mode_i || sel_sync_ff[1];
  wire [3:0] type_id = cfg_ff[CFG_TYPE_LSB +: 4];
  wire strap_hit = (sif.rx_byte[3:1] == strap_ff);
  wire dac_hit = (sif.rx_byte[7:4] == type_id) && strap_hit;
  wire cfg_hit = (sif.rx_byte[7:4] == CFG_TYPE_CODE) && strap_hit
                 && !cfg_ff[CFG_LOCK_BIT];
  wire is_rd = sif.rx_byte[0];
  wire [3:0] grp = sif.rx_byte[7:4];
  wire [1:0] low_sel = sif.rx_byte[1:0];
  wire grp_load = (grp == GRP_LOAD_ONE) || (grp == GRP_LOAD_TWO)
                  || (grp == GRP_LOAD_BOTH);
  wire grp_fixed = ((grp == GRP_CLEAR) || (grp == GRP_FILL))
                   && (sif.rx_byte[3:2] == 2'h3);
  wire grp_short = grp_fixed || (grp == GRP_RESTORE) || (grp == GRP_SLEEP);
  wire cmd_ok = grp_load || (grp_short && low_sel != 2'h0);
  wire [1:0] load_tgt_c = (cmd_ff[7:4] == GRP_LOAD_ONE) ? 2'b01 :
                          (cmd_ff[7:4] == GRP_LOAD_TWO) ? 2'b10 : 2'b11;
  // Low bit pattern 10 means channel one, 01 channel two
  wire [1:0] short_tgt = {low_sel[0], low_sel[1]};
  wire at_byte = sif.byte_p;

  // -----------------------------------------------------------
  // Sequencer next state and acknowledge decision
  // -----------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_ADDR: begin
        if (at_byte) begin
          if (!selected) begin
            nxt_state = ST_IDLE;
          end else if (dac_hit && !is_rd) begin
            nxt_state = ST_CMD;
          end else if (cfg_hit) begin
            nxt_state = is_rd ? ST_CFGRD : ST_CFG;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_CMD: begin
        if (at_byte) begin
          nxt_state = !cmd_ok ? ST_IDLE : (grp_load ? ST_DATA : ST_DONE);
        end
      end
      ST_DATA: begin
        if (at_byte) begin
          nxt_state = ST_DONE;
        end
      end
      ST_CFG: begin
        if (at_byte) begin
          nxt_state = ST_DONE;
        end
      end
      ST_CFGRD: begin
        nxt_state = ST_CFGRD;
      end
      ST_DONE: begin
        nxt_state = ST_DONE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (sif.start_p) begin
      nxt_state = ST_ADDR;
    end else if (sif.stop_p) begin
      nxt_state = ST_IDLE;
    end
  end

  // Acknowledge asked when a byte is accepted
  wire nxt_ack = (state_ff != ST_IDLE) && (nxt_state != ST_IDLE)
                 && (nxt_state != ST_DONE || state_ff != ST_DONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      ack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (at_byte) begin
        ack_ff <= nxt_ack && (state_ff != ST_CFGRD);
      end
    end
  end

  assign sif.ack_req = ack_ff;

  // -----------------------------------------------------------
  // Configuration read shifter
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_shift_ff <= 8'h00;
    end else if (state_ff == ST_ADDR && nxt_state == ST_CFGRD) begin
      rd_shift_ff <= cfg_ff;
    end else if (state_ff == ST_CFGRD && sif.byte_p) begin
      rd_shift_ff <= cfg_ff;
    end
  end

  assign sif.tx_en = (state_ff == ST_CFGRD) && (sif.byte_idx != 4'h0);
  assign sif.tx_bit = rd_shift_ff[3'h7 - sif.byte_idx[2:0]];

  // -----------------------------------------------------------
  // Command capture and pending nonvolatile store
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff <= 8'h00;
      pend_ff <= 10'h000;
      pend_tgt_ff <= 2'h0;
      pend_ff_valid <= 1'b0;
    end else begin
      if (sif.start_p || sif.stop_p) begin
        pend_ff_valid <= 1'b0;
      end
      if (state_ff == ST_CMD && at_byte) begin
        cmd_ff <= sif.rx_byte;
      end
      if (state_ff == ST_DATA && at_byte) begin
        pend_ff <= {cmd_ff[1:0], sif.rx_byte};
        pend_tgt_ff <= (cmd_ff[7:4] == GRP_LOAD_ONE) ? 2'b01 :
                       (cmd_ff[7:4] == GRP_LOAD_TWO) ? 2'b10 : 2'b11;
        pend_ff_valid <= 1'b1;
      end
    end
  end

  // Nonvolatile store only on stop after completed data byte
  wire nv_commit = sif.stop_p && pend_ff_valid && state_ff == ST_DONE;
  wire data_done = state_ff == ST_DATA && at_byte && selected;
  wire short_done = state_ff == ST_CMD && at_byte && grp_short && cmd_ok;
  wire [1:0] por_sel = cfg_ff[CFG_POR_LSB +: 2];

  // -----------------------------------------------------------
  // Channel, nonvolatile and sleep state per channel
  // -----------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chan_ff[ch] <= VAL_ZERO;
        nv_ff[ch] <= NV_RESET;
        sleep_ff[ch] <= 1'b0;
      end else if (!por_done_ff) begin
        chan_ff[ch] <= (por_sel == POR_ZERO) ? VAL_ZERO :
                       (por_sel == POR_ONES) ? VAL_FULL :
                       (por_sel == POR_MID) ? VAL_MID : nv_ff[ch];
      end else begin
        if (data_done && load_tgt_c[ch]) begin
          chan_ff[ch] <= {cmd_ff[1:0], sif.rx_byte};
        end else if (short_done && short_tgt[ch]) begin
          // Two-byte commands act at the command acknowledge
          if (grp == GRP_CLEAR) begin
            chan_ff[ch] <= VAL_ZERO;
          end else if (grp == GRP_FILL) begin
            chan_ff[ch] <= VAL_FULL;
          end else if (grp == GRP_RESTORE) begin
            chan_ff[ch] <= nv_ff[ch];
          end
        end
        if (short_done && short_tgt[ch] && grp == GRP_SLEEP) begin
          sleep_ff[ch] <= 1'b1;
        end else if ((data_done && load_tgt_c[ch])
                     || (short_done && short_tgt[ch] && grp != GRP_SLEEP)) begin
          sleep_ff[ch] <= 1'b0;
        end
        if (nv_commit && pend_tgt_ff[ch]) begin
          nv_ff[ch] <= pend_ff;
        end
      end
    end
  end

  // -----------------------------------------------------------
  // Configuration register and power-on load
  // -----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RESET;
      por_done_ff <= 1'b0;
    end else begin
      por_done_ff <= 1'b1;
      if (state_ff == ST_CFG && at_byte && !cfg_ff[CFG_LOCK_BIT]) begin
        cfg_ff <= sif.rx_byte;
      end
    end
  end

  // -----------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------
  assign chan_one_value_o = chan_ff[0];
  assign chan_two_value_o = chan_ff[1];
  assign nv_one_value_o = nv_ff[0];
  assign nv_two_value_o = nv_ff[1];
  assign sleep_o = sleep_ff;
  assign sleep_hiz_o = cfg_ff[CFG_PD_HIZ_BIT];
  assign dac_configuration_o = cfg_ff;
endmodule : dual_dac_serial_command_decoder

// >>> dac_bus_master.sv
// Two-wire bus master model that drives the serial clock and data line.
// Assumes an open-drain data line with a pull-up, resolved here.
`timescale 1ns/10ps
module dac_bus_master (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  // ----------------------------------------
  // Bus wire and bit timing
  // ----------------------------------------
  logic drv_low = 1'b0;
  // Pull-up wins unless a party pulls low
  assign sda_o = !(drv_low || sda_oe_i);
  // Clock stands high before the first frame and after each stop
  initial scl_o = 1'b1;

  // Quarter of a 320 ns bus bit
  task automatic q(input int n);
    repeat (2 * n) @(posedge clk_i);
    #1;
  endtask : q

  // Data falls while the clock is high
  task automatic start_c();
    drv_low = 1'b0;
    q(1);
    scl_o = 1'b1;
    q(1);
    drv_low = 1'b1;
    q(1);
    scl_o = 1'b0;
    q(1);
  endtask : start_c

  // Data rises while the clock is high
  task automatic stop_c();
    drv_low = 1'b1;
    q(1);
    scl_o = 1'b1;
    q(1);
    drv_low = 1'b0;
    q(3);
  endtask : stop_c

  // Eight bits MSB first, then the answer slot
  task automatic put_byte(input logic [7:0] b, output bit ak);
    for (int i = 7; i >= 0; i--) begin
      drv_low = !b[i];
      q(1);
      scl_o = 1'b1;
      q(2);
      scl_o = 1'b0;
      q(1);
    end
    drv_low = 1'b0; // Let the device answer
    q(1);
    scl_o = 1'b1;
    q(2);
    ak = !sda_o;
    scl_o = 1'b0;
    q(1);
  endtask : put_byte
endmodule : dac_bus_master

// >>> dual_dac_serial_command_decoder_asserts.sv
// Port checker for the dual channel command decoder.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module dual_dac_serial_command_decoder_asserts
  import dacdec_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic unit_sel_i,
  input wire logic unit_sel_mode_i,
  input wire logic [9:0] chan_one_value_o,
  input wire logic [9:0] nv_one_value_o,
  input wire logic [9:0] nv_two_value_o,
  input wire logic sleep_hiz_o,
  input wire logic [7:0] dac_configuration_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [1:0] por_sel = dac_configuration_o[2:1];
  // Power-on value picked by the config bits
  wire logic [9:0] por_one = (por_sel == POR_ZERO) ? VAL_ZERO : (por_sel == POR_ONES) ?
    VAL_FULL : (por_sel == POR_MID) ? VAL_MID : nv_one_value_o;

  property p_nv_one_on_stop;
    $changed(nv_one_value_o) |-> scl_i && $past(scl_i, 2);
  endproperty
  a_nv_one_on_stop: assert property (p_nv_one_on_stop)
    else $error("nv one changed outside a stop");
  property p_nv_two_on_stop;
    $changed(nv_two_value_o) |-> scl_i && $past(scl_i, 2);
  endproperty
  a_nv_two_on_stop: assert property (p_nv_two_on_stop)
    else $error("nv two changed outside a stop");
  property p_chan_one_acked;
    $changed(chan_one_value_o) && !$past(rst_i, 2) |-> ##[0:3] sda_oe_o;
  endproperty
  a_chan_one_acked: assert property (p_chan_one_acked)
    else $error("channel one changed without acknowledge");
  property p_hiz_follows_cfg;
    sleep_hiz_o == dac_configuration_o[CFG_PD_HIZ_BIT];
  endproperty
  a_hiz_follows_cfg: assert property (p_hiz_follows_cfg)
    else $error("sleep output state differs from config");
  property p_power_on_value;
    $fell(rst_i) |=> chan_one_value_o == por_one;
  endproperty
  a_power_on_value: assert property (p_power_on_value)
    else $error("wrong power-on channel value");
  property p_unselected_silent;
    (unit_sel_mode_i && !unit_sel_i) [*4] |-> !sda_oe_o;
  endproperty
  a_unselected_silent: assert property (p_unselected_silent)
    else $error("acknowledge while unit not selected");
  property p_locked_stable;
    dac_configuration_o[CFG_LOCK_BIT] |=> $stable(dac_configuration_o);
  endproperty
  a_locked_stable: assert property (p_locked_stable)
    else $error("locked config changed");
  property p_ack_length;
    $rose(sda_oe_o) |-> sda_oe_o [*6] ##[1:12] !sda_oe_o;
  endproperty
  a_ack_length: assert property (p_ack_length)
    else $error("acknowledge slot of wrong length");
endmodule : dual_dac_serial_command_decoder_asserts

bind dual_dac_serial_command_decoder dual_dac_serial_command_decoder_asserts u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .unit_sel_i(unit_sel_i),
  .unit_sel_mode_i(unit_sel_mode_i), .chan_one_value_o(chan_one_value_o),
  .nv_one_value_o(nv_one_value_o), .nv_two_value_o(nv_two_value_o),
  .sleep_hiz_o(sleep_hiz_o), .dac_configuration_o(dac_configuration_o));

// >>> dual_dac_serial_command_decoder_tb.sv
// Self-checking bench for the dual channel command decoder.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/10ps
module dual_dac_serial_command_decoder_tb;
  import dacdec_pkg::*;
  // ----------------------------------------
  // Bench signals and instances
  // ----------------------------------------
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] DEV = {DEFAULT_TYPE_ID, STRAP, 1'b0};
  localparam logic [7:0] CFG_W = {CFG_TYPE_CODE, STRAP, 1'b0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic unit_sel = 1'b0;
  logic unit_mode = 1'b0;
  logic scl, sda, sda_oe, hiz;
  logic [9:0] ch1, ch2, nv1, nv2;
  logic [1:0] sleep;
  logic [7:0] cfg;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  dual_dac_serial_command_decoder u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .strap_addr_i(STRAP), .unit_sel_i(unit_sel), .unit_sel_mode_i(unit_mode),
    .chan_one_value_o(ch1), .chan_two_value_o(ch2), .nv_one_value_o(nv1),
    .nv_two_value_o(nv2), .sleep_o(sleep), .sleep_hiz_o(hiz), .dac_configuration_o(cfg));
  dac_bus_master u_mst (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // Clock and hang guard
  always #20 clk_i = !clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Address, then n-1 more bytes, then an optional stop
  task automatic frame(input logic [7:0] a, c, d, input int n, input bit stp, output bit ak);
    bit k;
    u_mst.start_c();
    u_mst.put_byte(a, ak);
    if (n > 1) u_mst.put_byte(c, k);
    if (n > 2) u_mst.put_byte(d, k);
    if (stp) u_mst.stop_c();
  endtask : frame

  task automatic final_report();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Value writes with and without stop
  task automatic s_values();
    bit ak;
    frame(DEV, {GRP_LOAD_ONE, 4'h2}, 8'ha5, 3, 1, ak);
    check(ak, 1'b1, "write not acked");
    check(ch1, 10'h2a5, "channel one value");
    check(nv1, 10'h2a5, "nv one after stop");
    frame(DEV, {GRP_LOAD_TWO, 4'hd}, 8'h5a, 3, 0, ak);
    check(ch2, 10'h15a, "channel two value");
    check(nv2, NV_RESET, "nv two without stop");
    check(ch1, 10'h2a5, "channel one disturbed");
    frame(DEV, {GRP_LOAD_BOTH, 4'h3}, 8'hc3, 3, 1, ak);
    check(ch1, 10'h3c3, "both value one");
    check(ch2, 10'h3c3, "both value two");
    check(nv2, 10'h3c3, "both nv two");
  endtask : s_values

  // Every two-byte command on every selection
  task automatic s_two();
    logic [3:0] grp [4] = '{GRP_CLEAR, GRP_FILL, GRP_RESTORE, GRP_SLEEP};
    logic [9:0] ex;
    bit ak;
    for (int g = 0; g < 4; g++) begin
      for (int s = 1; s < 4; s++) begin
        frame(DEV, {GRP_LOAD_BOTH, 4'h1}, 8'h11, 3, 0, ak);
        frame(DEV, {grp[g], (g < 2) ? 2'b11 : 2'b00, s[1:0]}, 8'h00, 2, s[0], ak);
        ex = (g == 0) ? VAL_ZERO : (g == 1) ? VAL_FULL : (g == 2) ? 10'h3c3 : 10'h111;
        check(ak, 1'b1, "command not acked");
        check(ch1, s[1] ? ex : 10'h111, "command channel one");
        check(ch2, s[0] ? ex : 10'h111, "command channel two");
        check(sleep, (g == 3) ? {s[0], s[1]} : 2'b00, "sleep state");
        check(nv1, 10'h3c3, "command stored nv");
      end
    end
  endtask : s_two

  // Wrong address, unknown group, unit select
  task automatic s_refuse();
    bit ak;
    frame({DEFAULT_TYPE_ID, 3'h4, 1'b0}, {GRP_LOAD_ONE, 4'h0}, 8'h00, 3, 1, ak);
    check(ak, 1'b0, "wrong strap acked");
    frame(DEV, 8'hc3, 8'h00, 3, 1, ak);
    check(ch1, 10'h111, "unknown group changed channel");
    check(nv1, 10'h3c3, "unknown group changed nv");
    unit_mode = 1'b1;
    frame(DEV, {GRP_LOAD_ONE, 4'h0}, 8'h00, 3, 1, ak);
    check(ak, 1'b0, "unselected unit acked");
    check(ch1, 10'h111, "unselected unit written");
    unit_sel = 1'b1;
    frame(DEV, {GRP_LOAD_ONE, 4'h0}, 8'h07, 3, 1, ak);
    check(ch1, 10'h007, "selected unit not written");
    unit_mode = 1'b0;
    unit_sel = 1'b0;
  endtask : s_refuse

  // Config write, new type id, lock, then reset
  task automatic s_cfg();
    bit ak;
    frame(CFG_W, 8'h38, 8'h00, 2, 1, ak);
    check(cfg, 8'h38, "config write");
    check(hiz, 1'b1, "sleep high impedance");
    frame(DEV, {GRP_LOAD_TWO, 4'h0}, 8'h44, 3, 1, ak);
    check(ak, 1'b0, "old type acked");
    frame({4'h3, STRAP, 1'b0}, {GRP_LOAD_TWO, 4'h0}, 8'h44, 3, 1, ak);
    check(ch2, 10'h044, "new type not matched");
    frame(CFG_W, 8'h31, 8'h00, 2, 1, ak);
    frame(CFG_W, 8'h30, 8'h00, 2, 1, ak);
    check(ak, 1'b0, "locked config acked");
    check(cfg, 8'h31, "locked config changed");
    frame({CFG_TYPE_CODE, STRAP, 1'b1}, 8'h00, 8'h00, 1, 1, ak);
    check(ak, 1'b0, "locked config read acked");
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    check(cfg, CFG_RESET, "config reset value");
    check(ch1, NV_RESET, "power-on from nv");
  endtask : s_cfg

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    s_values();
    s_two();
    s_refuse();
    s_cfg();
    final_report();
  end
endmodule : dual_dac_serial_command_decoder_tb
